/* File: hw/csci_top.sv */
/*
 * Configuration input stage of the radio link physical layer: rate capping,
 * standby force, pointer, HDLC candidates, frame numbering, test timer, role,
 * and a small register port. Assumes configuration pins come from user logic
 * and the register master follows the one-cycle strobe protocol.
 */
`timescale 1ns/1ps
module csci_top #(
	parameter bit THREE_G = 1'b0,
	parameter logic [1:0] ETH_MODE = csci_pkg::ETH_FIXED100,
	parameter bit LOW_LATENCY = 1'b1,
	parameter int TIMER_CYCLES = csci_pkg::TIMER_NORMAL_CYCLES,
	parameter int HFN_WRAP = csci_pkg::HFN_PER_NFN
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [1:0] line_rate_limit_in,
	input wire logic startup_standby_force_in,
	input wire logic [1:0] serdes_rate_in,
	input wire logic [1:0] serdes_rate_report_in,
	input wire logic [7:0] fast_cm_pointer_in,
	input wire logic hdlc_240_en_in,
	input wire logic hdlc_480_en_in,
	input wire logic hdlc_960_en_in,
	input wire logic hdlc_1920_en_in,
	input wire logic hdlc_2400_en_in,
	input wire logic frame_auto_advance_in,
	input wire logic [7:0] hfn_seed_in,
	input wire logic [11:0] nfn_seed_in,
	input wire logic sync_clears_hfn_in,
	input wire logic sync_clears_nfn_in,
	input wire logic tx_frame_sync_in,
	input wire logic tx_hyperframe_tick_in,
	input wire logic fast_timer_test_in,
	input wire logic master_role_sel_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	output logic [1:0] line_rate_out,
	output logic serdes_reconfig_out,
	output logic standby_force_out,
	output logic [7:0] fast_cm_pointer_out,
	output logic [4:0] hdlc_candidates_out,
	output logic [2:0] hdlc_max_out,
	output logic [7:0] tx_hfn_out,
	output logic [11:0] tx_nfn_out,
	output logic timer_tick_out,
	output logic master_role_out,
	output logic [1:0] eth_mode_out
);
	localparam int TEST_CYCLES = TIMER_CYCLES / csci_pkg::TIMER_TEST_DIV;
	localparam logic [31:0] NORMAL_LOAD = 32'(TIMER_CYCLES - 1);
	localparam logic [31:0] TEST_LOAD = 32'(((TEST_CYCLES < 1) ? 1 : TEST_CYCLES) - 1);

	// Rate code supported by this build; code 3 folds to 2 without 3G
	function automatic logic [1:0] csci_fold(input logic [1:0] code);
		if (code == csci_pkg::RATE_3072 && !THREE_G) begin
			return csci_pkg::RATE_2457;
		end
		return code;
	endfunction : csci_fold

	logic stby_level;
	logic stby_rise;
	logic [7:0] hfn_cnt;
	logic [11:0] nfn_cnt;

	logic [1:0] ctrl_rate_reg;
	logic [1:0] ctrl_rate_next;
	logic [15:0] stby_cnt_reg;
	logic [15:0] stby_cnt_next;
	logic stby_out_reg;
	logic stby_out_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	csci_edge_sync u_stby_sync (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.level_in(startup_standby_force_in),
		.level_out(stby_level),
		.rise_out(stby_rise)
	);

	// Only the master numbers its own frames
	csci_frame_count #(
		.HFN_WRAP(HFN_WRAP)
	) u_frames (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.advance_in(frame_auto_advance_in & master_role_sel_in), // [RULE_06]
		.tick_in(tx_hyperframe_tick_in),
		.sync_in(tx_frame_sync_in),
		.clr_hfn_en_in(sync_clears_hfn_in),
		.clr_nfn_en_in(sync_clears_nfn_in),
		.hfn_seed_in(hfn_seed_in),
		.nfn_seed_in(nfn_seed_in),
		.hfn_out(hfn_cnt),
		.nfn_out(nfn_cnt)
	);

	// Rate negotiation: target is software choice capped by the folded limit
	logic [1:0] target_rate;
	logic [1:0] cap_rate;
	always_comb begin
		cap_rate = csci_fold(line_rate_limit_in); // [RULE_01]
		target_rate = (ctrl_rate_reg < cap_rate) ? ctrl_rate_reg : cap_rate;
	end

	csci_pkg::csci_reconf_e rc_reg;
	csci_pkg::csci_reconf_e rc_next;
	logic reconf_reg;
	logic reconf_next;
	logic [1:0] rate_reg;
	logic [1:0] rate_next;

	always_comb begin
		rc_next = rc_reg;
		reconf_next = reconf_reg;
		rate_next = rate_reg;
		unique case (rc_reg)
			csci_pkg::RC_IDLE: begin
				if (csci_fold(serdes_rate_in) != target_rate) begin // [RULE_03]
					rc_next = csci_pkg::RC_WAIT;
					reconf_next = 1'b1; // [RULE_15]
				end else begin
					rate_next = target_rate;
				end
			end
			csci_pkg::RC_WAIT: begin
				// Held until the outside logic reports the new rate
				if (csci_fold(serdes_rate_report_in) == target_rate) begin // [RULE_15]
					rc_next = csci_pkg::RC_IDLE;
					reconf_next = 1'b0;
					rate_next = target_rate;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			rc_reg <= csci_pkg::RC_IDLE;
			reconf_reg <= 1'b0;
			rate_reg <= csci_pkg::RATE_614;
		end else begin
			rc_reg <= rc_next;
			reconf_reg <= reconf_next;
			rate_reg <= rate_next;
		end
	end

	// Test timer; the test load is a fraction so startup runs quickly
	logic [31:0] timer_reg;
	logic [31:0] timer_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = 1'b0;
		if (timer_reg == 32'h0) begin
			timer_next = fast_timer_test_in ? TEST_LOAD : NORMAL_LOAD; // [RULE_11]
			tick_next = 1'b1;
		end else if (fast_timer_test_in && timer_reg > TEST_LOAD) begin
			timer_next = TEST_LOAD; // [RULE_11]
		end else begin
			timer_next = timer_reg - 32'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			timer_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			timer_reg <= timer_next;
			tick_reg <= tick_next;
		end
	end

	// Static pins: pointer, HDLC candidates and highest candidate, role
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic [4:0] hdlc_reg;
	logic [4:0] hdlc_next;
	logic [2:0] hmax_reg;
	logic [2:0] hmax_next;
	logic role_reg;
	logic role_next;

	always_comb begin
		// Out-of-range pointer is clamped, never sent as is
		ptr_next = (fast_cm_pointer_in > csci_pkg::PTR_MAX) ? csci_pkg::PTR_MAX
			: fast_cm_pointer_in; // [RULE_04]
		hdlc_next = {hdlc_2400_en_in, hdlc_1920_en_in, hdlc_960_en_in,
			hdlc_480_en_in, hdlc_240_en_in}; // [RULE_05]
		hmax_next = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (hdlc_next[i]) begin
				hmax_next = 3'(i + 1); // [RULE_05]
			end
		end
		role_next = master_role_sel_in; // [RULE_12]
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ptr_reg <= 8'h00;
			hdlc_reg <= 5'h00;
			hmax_reg <= 3'h0;
			role_reg <= 1'b0;
		end else begin
			ptr_reg <= ptr_next;
			hdlc_reg <= hdlc_next;
			hmax_reg <= hmax_next;
			role_reg <= role_next;
		end
	end

	// Register port and standby force
	always_comb begin
		ctrl_rate_next = ctrl_rate_reg;
		stby_cnt_next = stby_cnt_reg;
		stby_out_next = stby_rise; // [RULE_02]
		rdata_next = 32'h0;
		if (stby_rise) begin
			stby_cnt_next = stby_cnt_reg + 16'h1;
		end
		if (reg_write_in && reg_addr_in == csci_pkg::REG_CTRL) begin
			ctrl_rate_next = reg_wdata_in[2:1];
			stby_out_next = stby_rise | reg_wdata_in[csci_pkg::CTRL_STBY_BIT];
		end
		if (reg_read_in) begin
			unique case (reg_addr_in)
				csci_pkg::REG_CTRL: rdata_next = {29'h0, ctrl_rate_reg, 1'b0};
				csci_pkg::REG_STATUS: rdata_next = {19'h0, LOW_LATENCY, ETH_MODE,
					stby_level, role_reg, reconf_reg, hmax_reg, cap_rate, rate_reg};
				csci_pkg::REG_FRAME: rdata_next = {12'h0, nfn_cnt, hfn_cnt};
				csci_pkg::REG_STBY_CNT: rdata_next = {16'h0, stby_cnt_reg};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ctrl_rate_reg <= csci_pkg::CTRL_RATE_RST;
			stby_cnt_reg <= 16'h0;
			stby_out_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ctrl_rate_reg <= ctrl_rate_next;
			stby_cnt_reg <= stby_cnt_next;
			stby_out_reg <= stby_out_next;
			rdata_reg <= rdata_next;
		end
	end

	logic [7:0] hfn_o_reg;
	logic [11:0] nfn_o_reg;
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			hfn_o_reg <= csci_pkg::HFN_RST;
			nfn_o_reg <= csci_pkg::NFN_RST;
		end else begin
			hfn_o_reg <= hfn_cnt;
			nfn_o_reg <= nfn_cnt;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign line_rate_out = rate_reg;
	assign serdes_reconfig_out = reconf_reg;
	assign standby_force_out = stby_out_reg;
	assign fast_cm_pointer_out = ptr_reg;
	assign hdlc_candidates_out = hdlc_reg;
	assign hdlc_max_out = hmax_reg;
	assign tx_hfn_out = hfn_o_reg;
	assign tx_nfn_out = nfn_o_reg;
	assign timer_tick_out = tick_reg;
	assign master_role_out = role_reg;
	assign eth_mode_out = ETH_MODE; // [RULE_13]

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	a_rate_cap: assert property (line_rate_out <= csci_fold(line_rate_limit_in) // [RULE_01]
		|| serdes_reconfig_out || $changed(line_rate_limit_in))
		else $error("line rate above limit");
	a_standby_edge: assert property (!startup_standby_force_in [*2] ##1 // [RULE_02]
		startup_standby_force_in [*2] |-> ##4 standby_force_out)
		else $error("standby edge missed");
	a_standby_level: assert property (startup_standby_force_in [*8] ##1 !reg_write_in // [RULE_16]
		|=> !standby_force_out) else $error("standby acted on level");
	a_ptr_range: assert property (fast_cm_pointer_out <= csci_pkg::PTR_MAX) // [RULE_04]
		else $error("pointer out of range");
	a_hdlc_top: assert property (hdlc_2400_en_in |=> hdlc_max_out == 3'h5) // [RULE_05]
		else $error("hdlc max wrong");
	a_hfn_seed: assert property (!frame_auto_advance_in [*2] |=> tx_hfn_out == $past(hfn_seed_in, 2)) // [RULE_07]
		else $error("hfn not seeded");
	a_nfn_seed: assert property (!master_role_sel_in [*2] |=> tx_nfn_out == $past(nfn_seed_in, 2)) // [RULE_08]
		else $error("nfn not seeded");
	a_sync_hfn: assert property (tx_frame_sync_in && sync_clears_hfn_in // [RULE_09]
		&& frame_auto_advance_in && master_role_sel_in |-> ##2 tx_hfn_out == 8'h00)
		else $error("sync did not clear hfn");
	a_sync_nfn: assert property (tx_frame_sync_in && sync_clears_nfn_in // [RULE_10]
		&& frame_auto_advance_in && master_role_sel_in |-> ##2 tx_nfn_out == 12'h000)
		else $error("sync did not clear nfn");
	a_role_follow: assert property (##1 master_role_out == $past(master_role_sel_in)) // [RULE_12]
		else $error("role not followed");
	a_reconf_hold: assert property (serdes_reconfig_out && // [RULE_15]
		csci_fold(serdes_rate_report_in) != target_rate |=> serdes_reconfig_out)
		else $error("reconfig dropped early");
	a_fast_timer: assert property (fast_timer_test_in [*2] |-> timer_reg <= TEST_LOAD) // [RULE_11]
		else $error("test timer not shortened");
	a_low_latency: assert property (LOW_LATENCY == 1'b1) // [RULE_14]
		else $error("only low-latency build supported");

	c_standby: cover property (standby_force_out);
	c_reconf: cover property (serdes_reconfig_out ##[1:50] !serdes_reconfig_out);
	c_hfn_wrap: cover property (tx_hfn_out == 8'(HFN_WRAP - 1) ##[1:20] tx_hfn_out == 8'h00);
	c_tick: cover property (timer_tick_out);
endmodule : csci_top

/* File: hw/csci_pkg.sv */
/*
 * Constants shared by the static configuration block of the radio link
 * physical layer: rate codes, register map, reset values and timer counts.
 * Assumes a single 125 MHz core clock and a synchronous active-low reset.
 */
// How it works
// RULE_01: Limit select caps highest negotiated line rate
// RULE_02: Rising standby force sends startup to Standby
// RULE_03: SERDES rate select gives transceiver line rate
// RULE_04: Fast C&M pointer kept within 0..63
// RULE_05: Each HDLC enable offers one candidate rate
// RULE_06: Auto-advance lets master update frame numbers
// RULE_07: Hyperframe seed fills words or loads counter
// RULE_08: Node-frame seed fills words or loads counter
// RULE_09: Enabled sync pulse clears hyperframe index
// RULE_10: Enabled sync pulse clears node-frame index
// RULE_11: Fast-timer test input shortens internal timer
// RULE_12: Role select: zero RE, one REC
// RULE_13: Build option fixes Ethernet mode, default 100M
// RULE_14: Only low-latency build is supported
// RULE_15: Reconfig request until outside reports new rate
// RULE_16: Standby force registered, edge by sample compare
package csci_pkg;
	localparam logic [1:0] RATE_614 = 2'h0;
	localparam logic [1:0] RATE_1228 = 2'h1;
	localparam logic [1:0] RATE_2457 = 2'h2;
	localparam logic [1:0] RATE_3072 = 2'h3;

	localparam logic [1:0] ETH_SERIAL = 2'h0;
	localparam logic [1:0] ETH_MATCHED = 2'h1;
	localparam logic [1:0] ETH_FIXED100 = 2'h2;

	localparam logic [7:0] PTR_MAX = 8'h3f;
	localparam logic [7:0] HFN_RST = 8'h00;
	localparam logic [11:0] NFN_RST = 12'h000;
	localparam logic [11:0] NFN_LAST = 12'hfff;
	localparam logic AUTO_RST = 1'b1;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FRAME = 8'h08;
	localparam logic [7:0] REG_STBY_CNT = 8'h0c;
	localparam int CTRL_STBY_BIT = 0;
	localparam logic [1:0] CTRL_RATE_RST = 2'h3;

	localparam int CLK_PERIOD_NS = 8;
	localparam int TIMER_NORMAL_NS = 1000000;
	localparam int TIMER_NORMAL_CYCLES = TIMER_NORMAL_NS / CLK_PERIOD_NS;
	localparam int TIMER_TEST_DIV = 64;
	localparam int HFN_PER_NFN = 150;

	typedef enum logic [0:0] {
		RC_IDLE = 1'b0,
		RC_WAIT = 1'b1
	} csci_reconf_e;
endpackage : csci_pkg

/* File: hw/csci_edge_sync.sv */
/*
 * Three-stage sampler with rising-edge detection on the agreed level.
 * Assumes the input may come from any domain; output is four clocks late at least.
 */
`timescale 1ns/1ps
module csci_edge_sync (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic level_in,
	output logic level_out,
	output logic rise_out
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;

	always_comb begin
		stage_next = {stage_reg[1:0], level_in};
		level_next = level_reg;
		rise_next = 1'b0;
		// Stage one is read only by stage two
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
			rise_next = stage_reg[2] & ~level_reg; // [RULE_16]
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			stage_reg <= 3'h0;
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
			rise_reg <= rise_next;
		end
	end

	assign level_out = level_reg;
	assign rise_out = rise_reg;
endmodule : csci_edge_sync

/* File: hw/csci_frame_count.sv */
/*
 * Transmit hyperframe and node-frame numbering with seed load and sync clear.
 * Assumes tick and sync are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
module csci_frame_count #(
	parameter int HFN_WRAP = csci_pkg::HFN_PER_NFN
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic advance_in,
	input wire logic tick_in,
	input wire logic sync_in,
	input wire logic clr_hfn_en_in,
	input wire logic clr_nfn_en_in,
	input wire logic [7:0] hfn_seed_in,
	input wire logic [11:0] nfn_seed_in,
	output logic [7:0] hfn_out,
	output logic [11:0] nfn_out
);
	localparam logic [7:0] HFN_LAST = 8'(HFN_WRAP - 1);
	logic [7:0] hfn_reg;
	logic [7:0] hfn_next;
	logic [11:0] nfn_reg;
	logic [11:0] nfn_next;

	always_comb begin
		hfn_next = hfn_reg;
		nfn_next = nfn_reg;
		if (!advance_in) begin
			// Seeds drive the words; also preload for the next advance
			hfn_next = hfn_seed_in; // [RULE_07]
			nfn_next = nfn_seed_in; // [RULE_08]
		end else begin
			if (tick_in) begin
				if (hfn_reg == HFN_LAST) begin
					hfn_next = csci_pkg::HFN_RST;
					nfn_next = (nfn_reg == csci_pkg::NFN_LAST) ? csci_pkg::NFN_RST
						: nfn_reg + 12'h001;
				end else begin
					hfn_next = hfn_reg + 8'h01;
				end
			end
			// Sync beats the tick for an enabled index
			if (sync_in && clr_hfn_en_in) begin
				hfn_next = csci_pkg::HFN_RST; // [RULE_09]
			end
			if (sync_in && clr_nfn_en_in) begin
				nfn_next = csci_pkg::NFN_RST; // [RULE_10]
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			hfn_reg <= csci_pkg::HFN_RST;
			nfn_reg <= csci_pkg::NFN_RST;
		end else begin
			hfn_reg <= hfn_next;
			nfn_reg <= nfn_next;
		end
	end

	assign hfn_out = hfn_reg;
	assign nfn_out = nfn_reg;
endmodule : csci_frame_count

/* File: dv/csci_user_model.sv */
/*
 * Model of the user logic that reprograms the transceiver when asked.
 * Assumes the bench names the rate to program and how long it takes.
 */
`timescale 1ns/1ps
module csci_user_model (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic reconfig_in,
	input wire logic [1:0] want_rate_in,
	input wire logic [7:0] delay_in,
	output logic [1:0] serdes_rate_out,
	output logic [1:0] report_out
);
	logic [7:0] wait_reg;

	// Delay lets the bench play a prompt or a slow programmer
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			wait_reg <= 8'h00;
			serdes_rate_out <= 2'h0;
			report_out <= 2'h0;
		end else if (!reconfig_in) begin
			wait_reg <= 8'h00;
		end else if (wait_reg == delay_in) begin
			// Rate reported only once reprogramming is done
			serdes_rate_out <= want_rate_in;
			report_out <= want_rate_in;
		end else begin
			wait_reg <= wait_reg + 8'h01;
		end
	end
endmodule : csci_user_model

/* File: dv/csci_top_bench.sv */
/*
 * Self-checking bench for the configuration input stage.
 * Assumes the user model answers reprogramming requests on the rate lines.
 */
`timescale 1ns/1ps
module csci_top_bench;
	localparam int TCYC = 256;
	logic clk, rst_n, standby, tick, sync, clr_h, clr_n, fast_t, master, auto, wr, rd;
	logic [1:0] limit, want;
	logic [7:0] ptr, hseed, addr, p_delay;
	logic [11:0] nseed;
	logic [4:0] hdlc;
	logic [31:0] wdata, rdata, d;
	logic [1:0] serdes_rate, report, line_rate, eth_mode;
	logic reconfig, stby_out, timer_tick, role_out;
	logic [7:0] ptr_out, hfn;
	logic [11:0] nfn;
	logic [4:0] cand;
	logic [2:0] hmax;
	int fail_count, checks, n, i;

	// Short timer and wrap keep the run brief
	csci_top #(.TIMER_CYCLES(TCYC), .HFN_WRAP(8)) csci_top_i (.clock_in(clk),
		.reset_n_in(rst_n), .line_rate_limit_in(limit), .startup_standby_force_in(standby),
		.serdes_rate_in(serdes_rate), .serdes_rate_report_in(report),
		.fast_cm_pointer_in(ptr), .hdlc_240_en_in(hdlc[0]), .hdlc_480_en_in(hdlc[1]),
		.hdlc_960_en_in(hdlc[2]), .hdlc_1920_en_in(hdlc[3]), .hdlc_2400_en_in(hdlc[4]),
		.frame_auto_advance_in(auto), .hfn_seed_in(hseed), .nfn_seed_in(nseed),
		.sync_clears_hfn_in(clr_h), .sync_clears_nfn_in(clr_n), .tx_frame_sync_in(sync),
		.tx_hyperframe_tick_in(tick), .fast_timer_test_in(fast_t),
		.master_role_sel_in(master), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
		.line_rate_out(line_rate), .serdes_reconfig_out(reconfig),
		.standby_force_out(stby_out), .fast_cm_pointer_out(ptr_out),
		.hdlc_candidates_out(cand), .hdlc_max_out(hmax), .tx_hfn_out(hfn),
		.tx_nfn_out(nfn), .timer_tick_out(timer_tick), .master_role_out(role_out),
		.eth_mode_out(eth_mode));

	csci_user_model csci_user_model_i (.clock_in(clk), .reset_n_in(rst_n),
		.reconfig_in(reconfig), .want_rate_in(want), .delay_in(p_delay),
		.serdes_rate_out(serdes_rate), .report_out(report));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : reg_rd

	task automatic settle(input int c);
		repeat (c) @(negedge clk);
	endtask : settle

	// Bounded wait on the reprogramming request level
	task automatic wait_reconfig(input logic lvl, input int bound);
		int k;
		for (k = 0; k < bound && reconfig !== lvl; k++)
			@(negedge clk);
		if (reconfig !== lvl) begin
			$display("MISMATCH reconfig wait expected %h seen %h", lvl, reconfig);
			fail_count++;
			conclude();
		end
	endtask : wait_reconfig

	task automatic count_pulses(input int c, output int p);
		p = 0;
		repeat (c) begin
			@(negedge clk);
			if (stby_out === 1'b1)
				p++;
		end
	endtask : count_pulses

	task automatic tick_gap(output int g);
		int k;
		// Never read the tick in the time step of the edge that launches it
		@(negedge clk);
		for (k = 0; k < 600 && timer_tick !== 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		g = 1;
		while (timer_tick !== 1'b1 && g < 600) begin
			@(negedge clk);
			g++;
		end
		if (timer_tick !== 1'b1) begin
			$display("MISMATCH timer tick expected 1 seen %h", timer_tick);
			fail_count++;
			conclude();
		end
	endtask : tick_gap

	task automatic pulse_tick(input int c);
		repeat (c) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		settle(3);
	endtask : pulse_tick

	task automatic pulse_sync(input logic h, input logic f);
		@(posedge clk);
		clr_h <= h;
		clr_n <= f;
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		settle(3);
	endtask : pulse_sync

	task automatic test_static;
		chk("eth mode", 32'(csci_pkg::ETH_FIXED100), 32'(eth_mode));
		reg_rd(csci_pkg::REG_STATUS, d);
		chk("low latency", 32'h1, 32'(d[12]));
		settle(1);
		chk("rdata after read", 32'h0, rdata);
		reg_rd(8'h10, d);
		chk("unmapped read", 32'h0, d);
		$display("test static done");
	endtask : test_static

	task automatic test_standby;
		@(posedge clk);
		standby <= 1'b1;
		count_pulses(10, n);
		chk("standby rise", 32'h1, 32'(n));
		count_pulses(10, n);
		chk("standby level", 32'h0, 32'(n));
		@(posedge clk);
		standby <= 1'b0;
		count_pulses(10, n);
		chk("standby fall", 32'h0, 32'(n));
		reg_wr(csci_pkg::REG_CTRL, 32'h7);
		count_pulses(4, n);
		chk("standby by write", 32'h1, 32'(n));
		reg_rd(csci_pkg::REG_STBY_CNT, d);
		chk("standby edge count", 32'h1, d);
		reg_rd(csci_pkg::REG_CTRL, d);
		chk("ctrl readback", 32'h6, d);
		$display("test standby done");
	endtask : test_standby

	task automatic test_rate;
		@(posedge clk);
		want <= 2'h2;
		limit <= 2'h2;
		wait_reconfig(1'b1, 20);
		wait_reconfig(1'b0, 40);
		settle(2);
		chk("rate limit 2", 32'h2, 32'(line_rate));
		p_delay <= 8'h28;
		want <= 2'h1;
		reg_wr(csci_pkg::REG_CTRL, 32'h2);
		wait_reconfig(1'b1, 20);
		settle(20);
		chk("reconfig held", 32'h1, 32'(reconfig));
		wait_reconfig(1'b0, 60);
		settle(2);
		chk("rate requested 1", 32'h1, 32'(line_rate));
		@(posedge clk);
		p_delay <= 8'h00;
		want <= 2'h2;
		limit <= 2'h3;
		reg_wr(csci_pkg::REG_CTRL, 32'h6);
		wait_reconfig(1'b1, 20);
		wait_reconfig(1'b0, 40);
		settle(2);
		chk("rate limit 3 capped", 32'h2, 32'(line_rate));
		$display("test rate done");
	endtask : test_rate

	task automatic test_pins;
		// User logic keeps the pointer inside its legal range
		logic [7:0] pv[4] = '{8'h00, 8'h3f, 8'h20, 8'h15};
		logic [7:0] pe[4] = '{8'h00, 8'h3f, 8'h20, 8'h15};
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			ptr <= pv[i];
			settle(3);
			chk("pointer", 32'(pe[i]), 32'(ptr_out));
		end
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			hdlc <= 5'h01 << i;
			settle(3);
			chk("hdlc candidates", 32'(5'h01 << i), 32'(cand));
			chk("hdlc max", 32'(i + 1), 32'(hmax));
		end
		@(posedge clk);
		hdlc <= 5'h1f;
		settle(3);
		chk("hdlc max all", 32'h5, 32'(hmax));
		$display("test pins done");
	endtask : test_pins

	task automatic test_frames;
		@(posedge clk);
		auto <= 1'b0;
		hseed <= 8'h05;
		nseed <= 12'h007;
		settle(4);
		chk("hfn seed", 32'h5, 32'(hfn));
		chk("nfn seed", 32'h7, 32'(nfn));
		@(posedge clk);
		master <= 1'b1;
		auto <= 1'b1;
		settle(3);
		chk("role rec", 32'h1, 32'(role_out));
		pulse_tick(2);
		chk("hfn advance", 32'h7, 32'(hfn));
		pulse_sync(1'b1, 1'b0);
		chk("hfn cleared", 32'h0, 32'(hfn));
		chk("nfn kept", 32'h7, 32'(nfn));
		pulse_tick(1);
		pulse_sync(1'b0, 1'b1);
		chk("hfn kept", 32'h1, 32'(hfn));
		chk("nfn cleared", 32'h0, 32'(nfn));
		pulse_tick(7);
		chk("hfn wrap", 32'h0, 32'(hfn));
		chk("nfn carry", 32'h1, 32'(nfn));
		@(posedge clk);
		master <= 1'b0;
		settle(4);
		chk("role re", 32'h0, 32'(role_out));
		chk("re follows seed", 32'h5, 32'(hfn));
		reg_rd(csci_pkg::REG_FRAME, d);
		chk("frame reg", 32'h705, d);
		$display("test frames done");
	endtask : test_frames

	task automatic test_timer;
		@(posedge clk);
		fast_t <= 1'b1;
		tick_gap(n);
		tick_gap(n);
		chk("fast gap", 32'h1, 32'(n >= TCYC / 64 && n <= TCYC / 64 + 1));
		@(posedge clk);
		fast_t <= 1'b0;
		tick_gap(n);
		tick_gap(n);
		chk("normal gap", 32'h1, 32'(n >= TCYC && n <= TCYC + 1));
		$display("test timer done");
	endtask : test_timer

	initial begin
		fail_count = 0;
		checks = 0;
		rst_n = 1'b0;
		{standby, tick, sync, clr_h, clr_n, fast_t, master, wr, rd} = 9'h000;
		auto = 1'b1;
		limit = 2'h0;
		want = 2'h0;
		p_delay = 8'h00;
		ptr = 8'h00;
		hseed = 8'h00;
		nseed = 12'h000;
		hdlc = 5'h00;
		addr = 8'h00;
		wdata = 32'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		settle(2);
		test_static();
		test_standby();
		test_rate();
		test_pins();
		test_frames();
		test_timer();
		conclude();
	end
endmodule : csci_top_bench
